// *** src/asx_datapath.sv ***
// execution datapath: literal subtract, subtract with borrow, nibble swap,
// direction load and the two xor forms, with destination routing and flags
// assumes decode presents one operation per exec_valid pulse and that the
// register file returns file_rd_data for file_addr in the same cycle
// limitation: a file write lands one edge later, so a back-to-back op on
// the same address relies on a bypass inside the register file
`timescale 1ns/1ns
`default_nettype none
`include "asx_cfg.svh"
module asx_datapath
	import asx_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic exec_valid,
	input wire logic [2:0] exec_op,
	input wire logic [7:0] literal,
	input wire logic [6:0] file_addr,
	input wire logic dest_sel,
	input wire logic [2:0] dir_sel,
	input wire logic [7:0] file_rd_data,
	output logic [7:0] file_wr_data,
	output logic [6:0] file_wr_addr,
	output logic file_wr_en,
	output logic [7:0] acc,
	output logic carry_flag,
	output logic digit_carry_flag,
	output logic zero_flag,
	output logic [7:0] port_a_direction,
	output logic [7:0] port_b_direction,
	output logic [7:0] port_c_direction,
	output logic exec_done,
	output logic op_error
);
	asx_res_if res ();
	asx_state_t state;
	asx_state_t next_state;
	logic to_file;
	logic sets_arith_flags;
	logic sets_zero;
	logic dir_ok;
	logic do_lit_sub;
	logic do_sub_borrow;
	logic do_dir_load;
	logic do_lit_xor;
	logic do_reg_xor;

	// ----------------------------------------
	// operand hand-off to result unit
	// ----------------------------------------
	assign res.op = exec_valid ? exec_op : `ASX_OP_NONE;
	assign res.acc = acc;
	assign res.file_data = file_rd_data;
	assign res.literal = literal;
	assign res.carry_in = carry_flag;

	asx_result_unit u_result (
		.res(res)
	);

	// ----------------------------------------
	// decoded operation strobes
	// ----------------------------------------
	// one compare per opcode except swap, shared by the processes below; an idle
	// exec_valid or an unused code leaves every strobe low
	function automatic logic asx_is_op(input logic valid, input logic [2:0] op,
		input logic [2:0] code);
		return valid && op == code;
	endfunction

	assign do_lit_sub = asx_is_op(exec_valid, exec_op, `ASX_OP_LIT_SUB);
	assign do_sub_borrow = asx_is_op(exec_valid, exec_op, `ASX_OP_SUB_BORROW);
	assign do_dir_load = asx_is_op(exec_valid, exec_op, `ASX_OP_DIR_LOAD);
	assign do_lit_xor = asx_is_op(exec_valid, exec_op, `ASX_OP_LIT_XOR);
	assign do_reg_xor = asx_is_op(exec_valid, exec_op, `ASX_OP_REG_XOR);

	// ----------------------------------------
	// operation classification
	// ----------------------------------------
	// which ops may write back and which flags they touch
	function automatic logic asx_routable(input logic [2:0] op);
		return op == `ASX_OP_SUB_BORROW || op == `ASX_OP_SWAP || op == `ASX_OP_REG_XOR;
	endfunction

	always_comb begin
		to_file = exec_valid && asx_routable(exec_op) && dest_sel == `ASX_DEST_FILE;
		// subtracts own carry and digit carry
		sets_arith_flags = do_lit_sub || do_sub_borrow;
		sets_zero = sets_arith_flags || do_lit_xor || do_reg_xor;
		dir_ok = dir_sel >= `ASX_DIR_SEL_A && dir_sel <= `ASX_DIR_SEL_C;
	end

	// ----------------------------------------
	// accumulator
	// ----------------------------------------
	// literal forms always land in acc; routable ops only when dest is 0
	always_ff @(posedge mclk) begin
		if (rst) begin
			acc <= `ASX_ACC_RESET;
		end else if (exec_valid && !to_file) begin
			case (exec_op)
				`ASX_OP_LIT_SUB,
				`ASX_OP_LIT_XOR: acc <= res.result;
				// dest 0 keeps result in acc
				`ASX_OP_SUB_BORROW,
				`ASX_OP_SWAP,
				`ASX_OP_REG_XOR: acc <= res.result;
				default: acc <= acc;
			endcase
		end
	end

	// ----------------------------------------
	// file register write-back
	// ----------------------------------------
	// registered so the write lands one edge after execute, like acc
	always_ff @(posedge mclk) begin
		if (rst) begin
			file_wr_en <= 1'b0;
			file_wr_addr <= 7'h00;
			file_wr_data <= 8'h00;
		end else begin
			// dest 1 writes file register back
			file_wr_en <= to_file;
			if (to_file) begin
				file_wr_addr <= file_addr;
				file_wr_data <= res.result;
			end
		end
	end

	// ----------------------------------------
	// status flags
	// ----------------------------------------
	// swap and direction load leave every flag alone
	always_ff @(posedge mclk) begin
		if (rst) begin
			carry_flag <= `ASX_FLAG_RESET;
			digit_carry_flag <= `ASX_FLAG_RESET;
		end else if (sets_arith_flags) begin
			carry_flag <= res.carry_out;
			digit_carry_flag <= res.digit_carry_out;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			zero_flag <= `ASX_FLAG_RESET;
		end else if (sets_zero) begin
			zero_flag <= res.result == 8'h00;
		end
	end

	// ----------------------------------------
	// port direction registers
	// ----------------------------------------
	// reset to all inputs, the safe state for pins
	always_ff @(posedge mclk) begin
		if (rst) begin
			port_a_direction <= `ASX_DIR_RESET;
			port_b_direction <= `ASX_DIR_RESET;
			port_c_direction <= `ASX_DIR_RESET;
		end else if (do_dir_load) begin
			case (dir_sel)
				`ASX_DIR_SEL_A: port_a_direction <= acc;
				`ASX_DIR_SEL_B: port_b_direction <= acc;
				`ASX_DIR_SEL_C: port_c_direction <= acc;
				default: port_a_direction <= port_a_direction;
			endcase
		end
	end

	// ----------------------------------------
	// completion and error sequencing
	// ----------------------------------------
	// out-of-range direction operand loads nothing, flagged instead
	always_ff @(posedge mclk) begin
		if (rst) begin
			op_error <= 1'b0;
		end else begin
			op_error <= do_dir_load && !dir_ok;
		end
	end

	// two states only: done simply trails exec_valid by one edge
	always_comb begin
		case (state)
			ASX_IDLE: next_state = exec_valid ? ASX_DONE : ASX_IDLE;
			ASX_DONE: next_state = exec_valid ? ASX_DONE : ASX_IDLE;
			default: next_state = ASX_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state <= ASX_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// done marks the cycle in which results are visible
	// a level across a burst of requests, not one pulse per op
	assign exec_done = state == ASX_DONE;
endmodule
`default_nettype wire

// *** src/asx_cfg.svh ***
// constants for the subtract/xor/swap datapath: opcodes, operand limits, reset values
// assumes it is included by bare name from src/ files
`ifndef ASX_CFG_SVH
`define ASX_CFG_SVH

// ----------------------------------------
// operation select codes
// ----------------------------------------
`define ASX_OP_NONE 3'h0
`define ASX_OP_LIT_SUB 3'h1
`define ASX_OP_SUB_BORROW 3'h2
`define ASX_OP_SWAP 3'h3
`define ASX_OP_DIR_LOAD 3'h4
`define ASX_OP_LIT_XOR 3'h5
`define ASX_OP_REG_XOR 3'h6

// ----------------------------------------
// operand limits and direction targets
// ----------------------------------------
`define ASX_FILE_ADDR_MAX 7'h7f
`define ASX_DIR_SEL_A 3'h5
`define ASX_DIR_SEL_B 3'h6
`define ASX_DIR_SEL_C 3'h7
`define ASX_DEST_ACC 1'b0
`define ASX_DEST_FILE 1'b1

// ----------------------------------------
// reset values
// ----------------------------------------
`define ASX_ACC_RESET 8'h00
`define ASX_DIR_RESET 8'hff
`define ASX_FLAG_RESET 1'b0

`endif

// *** src/asx_pkg.sv ***
// types for the subtract/xor/swap datapath
// assumes asx_cfg.svh for numeric constants
package asx_pkg;
	typedef logic [7:0] asx_byte_t;
	typedef logic [2:0] asx_op_t;

	// arithmetic result with flags
	typedef struct packed {
		asx_byte_t value;
		logic carry;
		logic digit_carry;
	} asx_arith_t;

	// one-hot execute sequencing
	typedef enum logic [1:0] {
		ASX_IDLE = 2'b01,
		ASX_DONE = 2'b10
	} asx_state_t;
endpackage

// *** src/asx_res_if.sv ***
// carrier between datapath top and its result computing unit
// assumes both ends share mclk
`timescale 1ns/1ns
`default_nettype none
interface asx_res_if;
	import asx_pkg::*;
	asx_op_t op;
	asx_byte_t acc;
	asx_byte_t file_data;
	asx_byte_t literal;
	logic carry_in;
	asx_byte_t result;
	logic carry_out;
	logic digit_carry_out;
	modport top (output op, acc, file_data, literal, carry_in,
		input result, carry_out, digit_carry_out);
	modport unit (input op, acc, file_data, literal, carry_in,
		output result, carry_out, digit_carry_out);
endinterface
`default_nettype wire

// *** src/asx_result_unit.sv ***
// combinational result and flag computation for each operation
// assumes operands are stable while op is presented
`timescale 1ns/1ns
`default_nettype none
`include "asx_cfg.svh"
module asx_result_unit
	import asx_pkg::*;
(
	asx_res_if.unit res
);
	// ----------------------------------------
	// subtraction helper
	// ----------------------------------------
	// a - b - borrow as a + ~b + not_borrow; carry out is not-borrow
	function automatic asx_arith_t asx_sub(input asx_byte_t a, input asx_byte_t b,
		input logic not_borrow);
		logic [8:0] full;
		logic [4:0] low;
		asx_arith_t r;
		full = {1'b0, a} + {1'b0, ~b} + {8'h00, not_borrow};
		low = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, not_borrow};
		r.value = full[7:0];
		r.carry = full[8];
		r.digit_carry = low[4];
		return r;
	endfunction

	// ----------------------------------------
	// result select
	// ----------------------------------------
	// flags out are don't-care for ops that keep them; top ignores them there
	always_comb begin
		asx_arith_t s;
		s = '0;
		res.result = res.acc;
		res.carry_out = 1'b0;
		res.digit_carry_out = 1'b0;
		case (res.op)
			`ASX_OP_LIT_SUB: begin
				// no borrow in, carry set when acc not above literal
				s = asx_sub(res.literal, res.acc, 1'b1);
				res.result = s.value;
				res.carry_out = s.carry;
				res.digit_carry_out = s.digit_carry;
			end
			`ASX_OP_SUB_BORROW: begin
				s = asx_sub(res.file_data, res.acc, res.carry_in);
				res.result = s.value;
				res.carry_out = s.carry;
				res.digit_carry_out = s.digit_carry;
			end
			`ASX_OP_SWAP: res.result = {res.file_data[3:0], res.file_data[7:4]};
			`ASX_OP_LIT_XOR: res.result = res.acc ^ res.literal;
			`ASX_OP_REG_XOR: res.result = res.acc ^ res.file_data;
			default: res.result = res.acc;
		endcase
	end
endmodule
`default_nettype wire

// *** dv/asx_datapath_chk.sv ***
// checker for asx_datapath: results, routing and flags one cycle after a request
// assumes it is bound to asx_datapath and sees only its ports
`timescale 1ns/1ns
`default_nettype none
`include "asx_cfg.svh"
module asx_datapath_chk (
	input wire logic mclk,
	input wire logic rst,
	input wire logic exec_valid,
	input wire logic [2:0] exec_op,
	input wire logic [7:0] literal,
	input wire logic [6:0] file_addr,
	input wire logic dest_sel,
	input wire logic [2:0] dir_sel,
	input wire logic [7:0] file_rd_data,
	input wire logic [7:0] file_wr_data,
	input wire logic [6:0] file_wr_addr,
	input wire logic file_wr_en,
	input wire logic [7:0] acc,
	input wire logic carry_flag,
	input wire logic digit_carry_flag,
	input wire logic zero_flag,
	input wire logic [7:0] port_b_direction
);
	// ----------------------------------------
	// relations, all on mclk, off during reset
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	AST_LIT_SUB: assert property (exec_valid && exec_op == `ASX_OP_LIT_SUB |=>
		acc == $past(literal) - $past(acc)) else $error("literal subtract wrong");
	AST_LIT_SUB_ACC_ONLY: assert property (exec_valid && exec_op == `ASX_OP_LIT_SUB |=>
		!file_wr_en) else $error("literal subtract wrote file");
	AST_LIT_SUB_FLAGS: assert property (exec_valid && exec_op == `ASX_OP_LIT_SUB |=>
		carry_flag == ($past(acc) <= $past(literal)) &&
		digit_carry_flag == ($past(acc[3:0]) <= $past(literal[3:0])))
		else $error("literal subtract carries wrong");
	AST_BORROW_ACC: assert property (exec_valid && exec_op == `ASX_OP_SUB_BORROW
		&& !dest_sel |=> acc == $past(file_rd_data) - $past(acc) - {7'h00, !$past(carry_flag)})
		else $error("borrow subtract wrong");
	AST_BORROW_FILE: assert property (exec_valid && exec_op == `ASX_OP_SUB_BORROW
		&& dest_sel |=> file_wr_en && file_wr_addr == $past(file_addr) && $stable(acc))
		else $error("borrow subtract not written back");
	AST_SWAP_FILE: assert property (exec_valid && exec_op == `ASX_OP_SWAP && dest_sel |=>
		file_wr_en && file_wr_data == {$past(file_rd_data[3:0]), $past(file_rd_data[7:4])}
		&& $stable(carry_flag) && $stable(zero_flag)) else $error("swap wrong");
	AST_DIR_FLAGS: assert property (exec_valid && exec_op == `ASX_OP_DIR_LOAD |=>
		$stable({carry_flag, digit_carry_flag, zero_flag})) else $error("dir load moved flags");
	AST_DIR_B: assert property (exec_valid && exec_op == `ASX_OP_DIR_LOAD && dir_sel == 3'h6
		|=> port_b_direction == $past(acc)) else $error("port b direction not loaded");
	AST_LIT_XOR: assert property (exec_valid && exec_op == `ASX_OP_LIT_XOR |=>
		acc == ($past(acc) ^ $past(literal)) && zero_flag == (acc == 8'h00)
		&& $stable(carry_flag)) else $error("literal xor wrong");
	AST_REG_XOR_FILE: assert property (exec_valid && exec_op == `ASX_OP_REG_XOR
		&& dest_sel |=> file_wr_en && file_wr_data == ($past(acc) ^ $past(file_rd_data))
		&& file_wr_addr == $past(file_addr) && $stable(acc)) else $error("register xor wrong");
	AST_REG_XOR_ZERO: assert property (exec_valid && exec_op == `ASX_OP_REG_XOR |=>
		zero_flag == (($past(acc) ^ $past(file_rd_data)) == 8'h00)
		&& $stable({carry_flag, digit_carry_flag})) else $error("register xor flags wrong");
endmodule
// attach beside every datapath instance
bind asx_datapath asx_datapath_chk u_chk (.*);
`default_nettype wire

// *** dv/alu_subtract_xor_swap_ops_tb.sv ***
// self-checking bench for asx_datapath, driving its ports directly
// assumes asx_pkg and asx_cfg.svh; the bench stands in for the register file
`timescale 1ns/1ns
`default_nettype none
`include "asx_cfg.svh"
module alu_subtract_xor_swap_ops_tb;
	logic mclk = 0, rst = 1, vld = 0, ds = 0, we, c, dc, z, done, err;
	logic [2:0] op = 3'h0, dsel = 3'h5;
	logic [7:0] lit = 8'h00, frd = 8'h00, wd, acc, pa, pb, pc;
	logic [6:0] fa = 7'h7f, wa;
	int miscompares = 0, n_checks = 0;
	asx_datapath dut (.mclk(mclk), .rst(rst), .exec_valid(vld), .exec_op(op), .literal(lit),
		.file_addr(fa), .dest_sel(ds), .dir_sel(dsel), .file_rd_data(frd), .file_wr_data(wd),
		.file_wr_addr(wa), .file_wr_en(we), .acc(acc), .carry_flag(c), .digit_carry_flag(dc),
		.zero_flag(z), .port_a_direction(pa), .port_b_direction(pb), .port_c_direction(pc),
		.exec_done(done), .op_error(err));
	initial begin
		forever #25 mclk = ~mclk;
	end
	task automatic give_verdict;
		if (miscompares == 0 && n_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e) begin
			$display("mismatch %s expected %h seen %h", nm, e, g);
			miscompares++;
		end
	endtask
	// one request, released after its edge; file data turned over once not sampled
	task automatic go(input logic [2:0] o, input logic [7:0] k, input logic [7:0] f,
		input logic d, input logic [2:0] s);
		@(negedge mclk);
		vld = 1;
		op = o;
		lit = k;
		frd = f;
		ds = d;
		dsel = s;
		@(negedge mclk);
		vld = 0;
		frd = ~f;
	endtask
	// dest_sel high on literal ops must not reach the file
	task automatic t_lit;
		go(`ASX_OP_LIT_XOR, 8'h35, 8'h00, 1, 3'h0);
		chk("xor acc", 8'h35, acc);
		go(`ASX_OP_LIT_SUB, 8'h35, 8'h00, 1, 3'h0);
		chk("equal acc", 8'h00, acc);
		chk("equal we", 8'h00, {7'h00, we});
		chk("equal flags", 8'h07, {5'h00, c, dc, z});
		go(`ASX_OP_LIT_XOR, 8'h02, 8'h00, 0, 3'h0);
		chk("xor flags", 8'h06, {5'h00, c, dc, z});
		go(`ASX_OP_LIT_SUB, 8'h01, 8'h00, 0, 3'h0);
		chk("under acc", 8'hff, acc);
		chk("under flags", 8'h00, {5'h00, c, dc, z});
	endtask
	// inverted carry enters as borrow; both destinations
	task automatic t_borrow;
		go(`ASX_OP_SUB_BORROW, 8'h00, 8'h10, 1, 3'h0);
		chk("bw data", 8'h10, wd);
		chk("bw addr", 8'h7f, {1'b0, wa});
		chk("bw acc", 8'hff, acc);
		chk("bw flags", 8'h00, {5'h00, c, dc, z});
		go(`ASX_OP_SUB_BORROW, 8'h00, 8'h00, 0, 3'h0);
		chk("bw zero", 8'h01, {6'h00, we, z});
		go(`ASX_OP_SUB_BORROW, 8'h00, 8'h01, 0, 3'h0);
		chk("bw carry", 8'h07, {5'h00, c, dc, z});
		go(`ASX_OP_SUB_BORROW, 8'h00, 8'h10, 0, 3'h0);
		chk("bw cin acc", 8'h10, acc);
		chk("bw cin flags", 8'h06, {5'h00, c, dc, z});
	endtask
	task automatic t_swap;
		go(`ASX_OP_SWAP, 8'h00, 8'ha5, 1, 3'h0);
		chk("sw file", 8'h5a, wd);
		go(`ASX_OP_SWAP, 8'h00, 8'ha5, 0, 3'h0);
		chk("sw acc", 8'h5a, acc);
		chk("sw flags", 8'h06, {5'h00, c, dc, z});
	endtask
	// out-of-range target first, then each port, with acc inverted before B and before C
	task automatic t_dir;
		go(`ASX_OP_DIR_LOAD, 8'h00, 8'h00, 0, 3'h4);
		chk("dir bad", 8'h01, {7'h00, err});
		chk("dir bad a", 8'hff, pa & pb & pc);
		go(`ASX_OP_DIR_LOAD, 8'h00, 8'h00, 0, 3'h5);
		go(`ASX_OP_LIT_XOR, 8'hff, 8'h00, 0, 3'h0);
		go(`ASX_OP_DIR_LOAD, 8'h00, 8'h00, 0, 3'h6);
		go(`ASX_OP_LIT_XOR, 8'hff, 8'h00, 0, 3'h0);
		go(`ASX_OP_DIR_LOAD, 8'h00, 8'h00, 0, 3'h7);
		chk("dir a", 8'h5a, pa);
		chk("dir b", 8'ha5, pb);
		chk("dir c", 8'h5a, pc);
		chk("dir flags", 8'h06, {5'h00, c, dc, z});
	endtask
	task automatic t_reg_xor;
		fa = 7'h05;
		go(`ASX_OP_REG_XOR, 8'h00, 8'h5a, 1, 3'h0);
		chk("rx file", 8'h00, wd);
		chk("rx addr", 8'h05, {1'b0, wa});
		chk("rx flags", 8'h07, {5'h00, c, dc, z});
		go(`ASX_OP_REG_XOR, 8'h00, 8'h0f, 0, 3'h0);
		chk("rx acc", 8'h55, acc);
		chk("rx we", 8'h00, {7'h00, we});
	endtask
	// back to back: second op sees the first's acc; idle codes change nothing
	task automatic t_b2b;
		@(negedge mclk);
		vld = 1;
		op = `ASX_OP_LIT_XOR;
		lit = 8'h0f;
		ds = 0;
		@(negedge mclk);
		chk("b2b done", 8'h01, {7'h00, done});
		lit = 8'hf0;
		@(negedge mclk);
		vld = 0;
		chk("b2b acc", 8'haa, acc);
		go(3'h7, 8'h33, 8'h33, 1, 3'h0);
		go(`ASX_OP_NONE, 8'h33, 8'h33, 1, 3'h0);
		chk("idle acc", 8'haa, acc);
		chk("idle we flags", 8'h06, {4'h0, we, c, dc, z});
		// mid-run reset for one edge
		rst = 1;
		@(negedge mclk);
		rst = 0;
		chk("rst acc", 8'h00, acc);
		chk("rst flags", 8'h00, {5'h00, c, dc, z});
		chk("rst done", 8'h00, {7'h00, done});
	endtask
	// watchdog well past the roughly 45 cycles needed
	initial begin
		#200000;
		miscompares++;
		give_verdict();
	end
	initial begin
		repeat (3) @(posedge mclk);
		@(negedge mclk);
		rst = 0;
		chk("rst dir", 8'hff, pa);
		t_lit();
		t_borrow();
		t_swap();
		t_dir();
		t_reg_xor();
		t_b2b();
		give_verdict();
	end
endmodule
`default_nettype wire
